// ### rtl/tmc_core.sv
/*
  Tiny 8-bit microcontroller core: two-cycle fetch/execute sequencer,
  ALU with zero and carry, jumps, calls, port I/O and one interrupt.
  Assumes a synchronous program ROM returning the word one cycle after
  the address, and user port logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tmc_core (
  // Clock and reset
  input  wire logic                   i_clock,
  input  wire logic                   i_arst_n,
  // Program ROM
  output logic          [7:0]         o_address,
  input  wire logic     [15:0]        i_instruction,
  // User ports
  output var tmc_pkg::tmc_port_out_t  o_port,
  input  wire logic     [7:0]         i_in_data,
  // Interrupt
  input  wire logic                   i_interrupt
);

  tmc_pkg::tmc_core_state_t s_q;
  tmc_pkg::tmc_core_state_t s_d;

  logic [3:0] op;
  logic [3:0] reg_x;
  logic [3:0] reg_y;
  logic [7:0] konst;
  logic [2:0] cond;
  logic [7:0] reg_a;
  logic [7:0] reg_b;
  logic [7:0] stack_top;
  logic       rf_we;
  logic [3:0] rf_waddr;
  logic [7:0] rf_wdata;
  logic       st_push;
  logic       st_pop;
  logic [7:0] st_data;
  logic [7:0] pc_next;
  logic       cond_ok;
  logic [2:0] alu_sel;
  logic [7:0] alu_b;
  logic [8:0] alu_sum;
  logic [7:0] alu_res;
  logic       alu_carry;
  logic       alu_flags;
  logic [7:0] sh_res;
  logic       sh_carry;

  // Instruction fields
  assign op    = i_instruction[15:12];
  assign reg_x = i_instruction[11:8];
  assign reg_y = i_instruction[7:4];
  assign konst = i_instruction[7:0];
  assign cond  = i_instruction[10:8];

  tmc_regfile #(
    .WIDTH (8),
    .DEPTH (tmc_pkg::NUM_REGS),
    .AW    (4)
  ) u_regfile (
    .i_clock   (i_clock),
    .i_we      (rf_we),
    .i_waddr   (rf_waddr),
    .i_wdata   (rf_wdata),
    .i_raddr_a (reg_x),
    .i_raddr_b (reg_y),
    .o_rdata_a (reg_a),
    .o_rdata_b (reg_b)
  );

  tmc_stack #(
    .WIDTH (8),
    .DEPTH (tmc_pkg::STACK_DEPTH),
    .PW    (4)
  ) u_stack (
    .i_clock  (i_clock),
    .i_arst_n (i_arst_n),
    .i_push   (st_push),
    .i_pop    (st_pop),
    .i_data   (st_data),
    .o_top    (stack_top)
  );

  // Wraps from the top address to zero
  assign pc_next = s_q.pc + 8'h01;

  // Only zero and carry steer program flow
  always_comb begin
    case (cond)
      tmc_pkg::CND_Z:  cond_ok = s_q.zero;
      tmc_pkg::CND_NZ: cond_ok = !s_q.zero;
      tmc_pkg::CND_C:  cond_ok = s_q.carry;
      tmc_pkg::CND_NC: cond_ok = !s_q.carry;
      default:         cond_ok = (cond[2] == 1'b0);
    endcase
  end

  // Two-operand ALU; second operand register or constant
  always_comb begin
    alu_sel   = (op == tmc_pkg::OP_ALU_RR) ? i_instruction[2:0] : op[2:0];
    alu_b     = (op == tmc_pkg::OP_ALU_RR) ? reg_b : konst;
    alu_sum   = 9'h000;
    alu_res   = reg_a;
    alu_carry = s_q.carry;
    alu_flags = 1'b1;
    case ({1'b0, alu_sel})
      tmc_pkg::OP_LOAD: begin
        alu_res   = alu_b;
        alu_flags = 1'b0;
      end
      tmc_pkg::OP_AND: begin
        alu_res   = reg_a & alu_b;
        alu_carry = 1'b0;
      end
      tmc_pkg::OP_OR: begin
        alu_res   = reg_a | alu_b;
        alu_carry = 1'b0;
      end
      tmc_pkg::OP_XOR: begin
        alu_res   = reg_a ^ alu_b;
        alu_carry = 1'b0;
      end
      tmc_pkg::OP_ADD, tmc_pkg::OP_ADDCY: begin
        // Carry-in only for the chained variant
        alu_sum   = {1'b0, reg_a} + {1'b0, alu_b}
                  + {8'h00, (alu_sel[0] & s_q.carry)};
        alu_res   = alu_sum[7:0];
        alu_carry = alu_sum[8];
      end
      default: begin
        // Subtract; carry is the borrow out
        alu_sum   = {1'b0, reg_a} - {1'b0, alu_b}
                  - {8'h00, (alu_sel[0] & s_q.carry)};
        alu_res   = alu_sum[7:0];
        alu_carry = alu_sum[8];
      end
    endcase
  end

  // Shift and rotate group; carry takes the bit shifted out
  always_comb begin
    sh_res   = reg_a;
    sh_carry = s_q.carry;
    case (i_instruction[3:0])
      tmc_pkg::SH_SR0: {sh_res, sh_carry} = {1'b0, reg_a};
      tmc_pkg::SH_SR1: {sh_res, sh_carry} = {1'b1, reg_a};
      tmc_pkg::SH_SRX: {sh_res, sh_carry} = {reg_a[7], reg_a};
      tmc_pkg::SH_SRA: {sh_res, sh_carry} = {s_q.carry, reg_a};
      tmc_pkg::SH_RR:  {sh_res, sh_carry} = {reg_a[0], reg_a};
      tmc_pkg::SH_SL0: {sh_carry, sh_res} = {reg_a, 1'b0};
      tmc_pkg::SH_SL1: {sh_carry, sh_res} = {reg_a, 1'b1};
      tmc_pkg::SH_SLX: {sh_carry, sh_res} = {reg_a, reg_a[0]};
      tmc_pkg::SH_SLA: {sh_carry, sh_res} = {reg_a, s_q.carry};
      tmc_pkg::SH_RL:  {sh_carry, sh_res} = {reg_a, reg_a[7]};
      default: begin
        sh_res   = reg_a;
        sh_carry = s_q.carry;
      end
    endcase
  end

  // Sequencer: fetch then execute, always two cycles
  always_comb begin
    s_d                = s_q;
    s_d.port.rd_strobe = 1'b0;
    s_d.port.wr_strobe = 1'b0;
    rf_we              = 1'b0;
    rf_waddr           = reg_x;
    rf_wdata           = alu_res;
    st_push            = 1'b0;
    st_pop             = 1'b0;
    st_data            = pc_next;
    case (s_q.state)
      tmc_pkg::ST_FETCH: begin
        s_d.state = tmc_pkg::ST_EXEC;
        // Byte sampled while the read strobe is high
        if (s_q.port.rd_strobe) begin
          rf_we    = 1'b1;
          rf_waddr = s_q.in_dest;
          rf_wdata = i_in_data;
        end
      end
      tmc_pkg::ST_EXEC: begin
        s_d.state = tmc_pkg::ST_FETCH;
        s_d.pc    = pc_next;
        if (s_q.int_en && i_interrupt) begin
          // Fetched word is dropped and re-run after the handler
          st_push         = 1'b1;
          st_data         = s_q.pc;
          s_d.pc          = tmc_pkg::INT_VECTOR;
          s_d.saved_zero  = s_q.zero;
          s_d.saved_carry = s_q.carry;
          s_d.int_en      = 1'b0;
        end else begin
          case (op)
            tmc_pkg::OP_LOAD, tmc_pkg::OP_AND, tmc_pkg::OP_OR,
            tmc_pkg::OP_XOR, tmc_pkg::OP_ADD, tmc_pkg::OP_ADDCY,
            tmc_pkg::OP_SUB, tmc_pkg::OP_SUBCY, tmc_pkg::OP_ALU_RR: begin
              rf_we  = 1'b1;
              if (alu_flags) begin
                s_d.zero  = (alu_res == 8'h00);
                s_d.carry = alu_carry;
              end
            end
            tmc_pkg::OP_SHIFT: begin
              rf_we     = 1'b1;
              rf_wdata  = sh_res;
              s_d.zero  = (sh_res == 8'h00);
              s_d.carry = sh_carry;
            end
            tmc_pkg::OP_IN_K, tmc_pkg::OP_OUT_K, tmc_pkg::OP_IO_IND: begin
              // Select from constant or from register y
              s_d.port.port_select = (op == tmc_pkg::OP_IO_IND) ? reg_b : konst;
              if (op == tmc_pkg::OP_OUT_K
                  || (op == tmc_pkg::OP_IO_IND && i_instruction[0])) begin
                s_d.port.out_data  = reg_a;
                s_d.port.wr_strobe = 1'b1;
              end else begin
                s_d.in_dest        = reg_x;
                s_d.port.rd_strobe = 1'b1;
              end
            end
            tmc_pkg::OP_JUMP: begin
              if (cond_ok) begin
                s_d.pc = konst;
              end
            end
            tmc_pkg::OP_CALL: begin
              if (cond_ok) begin
                st_push = 1'b1;
                s_d.pc  = konst;
              end
            end
            default: begin
              case (i_instruction[7:4])
                tmc_pkg::MS_RETURN: begin
                  if (cond_ok) begin
                    st_pop = 1'b1;
                    s_d.pc = stack_top;
                  end
                end
                tmc_pkg::MS_INT_RETURN: begin
                  st_pop     = 1'b1;
                  s_d.pc     = stack_top;
                  s_d.zero   = s_q.saved_zero;
                  s_d.carry  = s_q.saved_carry;
                  s_d.int_en = i_instruction[0];
                end
                tmc_pkg::MS_INT_ENABLE:  s_d.int_en = 1'b1;
                tmc_pkg::MS_INT_DISABLE: s_d.int_en = 1'b0;
                default: s_d.int_en = s_q.int_en;
              endcase
            end
          endcase
        end
      end
      default: begin
        s_d.state = tmc_pkg::ST_FETCH;
      end
    endcase
  end

  // Reset: pc zero, flags clear, interrupts off
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q.state            <= tmc_pkg::ST_FETCH;
      s_q.pc               <= tmc_pkg::RESET_PC;
      s_q.zero             <= 1'b0;
      s_q.carry            <= 1'b0;
      s_q.saved_zero       <= 1'b0;
      s_q.saved_carry      <= 1'b0;
      s_q.int_en           <= 1'b0;
      s_q.in_dest          <= 4'h0;
      s_q.port.port_select <= 8'h00;
      s_q.port.out_data    <= 8'h00;
      s_q.port.rd_strobe   <= 1'b0;
      s_q.port.wr_strobe   <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Address held through fetch; ROM latches it at fetch end
  assign o_address = s_q.pc;
  // Select and data change only with a new access
  assign o_port    = s_q.port;

endmodule // tmc_core
`default_nettype wire

// ### rtl/tmc_pkg.sv
/*
  Package of the tiny 8-bit microcontroller core: instruction fields,
  opcodes, condition codes, reset values and the state and port carriers.
  Assumes a 16-bit program word from a synchronous 256-word ROM.
*/
// Summary of operation
// - Sixteen equal 8-bit general-purpose registers.
// - ALU result returns to first operand register.
// - Second operand: register or inline 8-bit constant.
// - Add and subtract have carry-in variants.
// - ALU sets zero, carry except on load; only tested conditions.
// - Jumps load absolute address, optionally conditional.
// - Call pushes return address; return pops it.
// - Return stack nests fifteen levels deep.
// - Reset restarts at zero, interrupts disabled.
// - Reset clears flags and empties stack.
// - Reset leaves general-purpose registers untouched.
// - 256 ports via 8-bit select, strobes.
// - Port select from constant or any register.
// - Input copies byte to register, read strobe.
// - Output drives register byte, write strobe.
// - One interrupt input, disabled by default, programmable.
// - Enabled interrupt calls last program location.
// - Interrupt saves flags and disables interrupts.
// - Interrupt return restores flags, sets enable from bit 0.
// - Program store holds 256 instructions.
// - Every instruction takes exactly two cycles.
// - 16-bit instructions, 8-bit program address.
// - Program counter increments and wraps at top.
package tmc_pkg;

  localparam int unsigned NUM_REGS    = 16;
  localparam int unsigned STACK_DEPTH = 15;

  localparam logic [7:0] RESET_PC   = 8'h00;
  localparam logic [7:0] INT_VECTOR = 8'hff;

  // Opcode field [15:12]; 0..7 are ALU ops with inline constant
  localparam logic [3:0] OP_LOAD   = 4'h0;
  localparam logic [3:0] OP_AND    = 4'h1;
  localparam logic [3:0] OP_OR     = 4'h2;
  localparam logic [3:0] OP_XOR    = 4'h3;
  localparam logic [3:0] OP_ADD    = 4'h4;
  localparam logic [3:0] OP_ADDCY  = 4'h5;
  localparam logic [3:0] OP_SUB    = 4'h6;
  localparam logic [3:0] OP_SUBCY  = 4'h7;
  localparam logic [3:0] OP_ALU_RR = 4'h8;
  localparam logic [3:0] OP_SHIFT  = 4'h9;
  localparam logic [3:0] OP_IN_K   = 4'ha;
  localparam logic [3:0] OP_OUT_K  = 4'hb;
  localparam logic [3:0] OP_IO_IND = 4'hc;
  localparam logic [3:0] OP_JUMP   = 4'hd;
  localparam logic [3:0] OP_CALL   = 4'he;
  localparam logic [3:0] OP_MISC   = 4'hf;

  // Condition field [10:8]
  localparam logic [2:0] CND_ALWAYS = 3'h0;
  localparam logic [2:0] CND_Z      = 3'h4;
  localparam logic [2:0] CND_NZ     = 3'h5;
  localparam logic [2:0] CND_C      = 3'h6;
  localparam logic [2:0] CND_NC     = 3'h7;

  // Shift field [3:0]
  localparam logic [3:0] SH_SR0 = 4'h0;
  localparam logic [3:0] SH_SR1 = 4'h1;
  localparam logic [3:0] SH_SRX = 4'h2;
  localparam logic [3:0] SH_SRA = 4'h3;
  localparam logic [3:0] SH_RR  = 4'h4;
  localparam logic [3:0] SH_SL0 = 4'h8;
  localparam logic [3:0] SH_SL1 = 4'h9;
  localparam logic [3:0] SH_SLX = 4'ha;
  localparam logic [3:0] SH_SLA = 4'hb;
  localparam logic [3:0] SH_RL  = 4'hc;

  // Misc field [7:4]
  localparam logic [3:0] MS_RETURN     = 4'h0;
  localparam logic [3:0] MS_INT_RETURN = 4'h1;
  localparam logic [3:0] MS_INT_ENABLE = 4'h2;
  localparam logic [3:0] MS_INT_DISABLE= 4'h3;

  typedef enum logic [1:0] {
    ST_FETCH = 2'b01,
    ST_EXEC  = 2'b10
  } tmc_state_t;

  typedef struct packed {
    logic [7:0] port_select;
    logic [7:0] out_data;
    logic       rd_strobe;
    logic       wr_strobe;
  } tmc_port_out_t;

  typedef struct packed {
    tmc_state_t    state;
    logic [7:0]    pc;
    logic          zero;
    logic          carry;
    logic          saved_zero;
    logic          saved_carry;
    logic          int_en;
    logic [3:0]    in_dest;
    tmc_port_out_t port;
  } tmc_core_state_t;

endpackage

// ### rtl/tmc_regfile.sv
/*
  General-purpose register file: one write port, two read ports.
  Assumes writes come from the core on the same clock; has no reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tmc_regfile #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW    = 4
) (
  // Clock
  input  wire logic             i_clock,
  // Write port
  input  wire logic             i_we,
  input  wire logic [AW-1:0]    i_waddr,
  input  wire logic [WIDTH-1:0] i_wdata,
  // Read ports
  input  wire logic [AW-1:0]    i_raddr_a,
  input  wire logic [AW-1:0]    i_raddr_b,
  output logic      [WIDTH-1:0] o_rdata_a,
  output logic      [WIDTH-1:0] o_rdata_b
);

  logic [DEPTH-1:0][WIDTH-1:0] mem_q;
  logic [DEPTH-1:0][WIDTH-1:0] mem_d;

  always_comb begin
    mem_d = mem_q;
    if (i_we) begin
      mem_d[i_waddr] = i_wdata;
    end
  end

  // No reset: contents survive a core reset
  always_ff @(posedge i_clock) begin
    mem_q <= mem_d;
  end

  // Read data straight from the register flops
  assign o_rdata_a = mem_q[i_raddr_a];
  assign o_rdata_b = mem_q[i_raddr_b];

endmodule // tmc_regfile
`default_nettype wire

// ### rtl/tmc_stack.sv
/*
  Circular return-address stack for calls and interrupts.
  Assumes push and pop never arrive in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module tmc_stack #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 15,
  parameter int unsigned PW    = 4
) (
  // Clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_arst_n,
  // Control
  input  wire logic             i_push,
  input  wire logic             i_pop,
  input  wire logic [WIDTH-1:0] i_data,
  // Top of stack
  output logic      [WIDTH-1:0] o_top
);

  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [DEPTH-1:0][WIDTH-1:0] mem_q;
  logic [DEPTH-1:0][WIDTH-1:0] mem_d;
  logic [PW-1:0]               ptr_q;
  logic [PW-1:0]               ptr_d;
  logic [PW-1:0]               top_idx;

  // Deeper nesting silently overwrites the oldest entry
  always_comb begin
    top_idx = (ptr_q == '0) ? LAST : ptr_q - PW'(1);
    mem_d   = mem_q;
    ptr_d   = ptr_q;
    if (i_push) begin
      mem_d[ptr_q] = i_data;
      ptr_d        = (ptr_q == LAST) ? '0 : ptr_q + PW'(1);
    end else if (i_pop) begin
      ptr_d = top_idx;
    end
  end

  always_ff @(posedge i_clock) begin
    mem_q <= mem_d;
  end

  // Reset empties the stack
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ptr_q <= '0;
    end else begin
      ptr_q <= ptr_d;
    end
  end

  assign o_top = mem_q[top_idx];

endmodule // tmc_stack
`default_nettype wire

// ### bench/tmc_core_assertions.sv
/*
  Port-timing checker for tmc_core, bound below.
  Assumes the ROM answers one cycle after the address.
*/
`timescale 1ns/1ps
`default_nettype none
module tmc_core_assertions (
  input wire logic                   i_clock,
  input wire logic                   i_arst_n,
  input wire logic [7:0]             o_address,
  input wire logic [15:0]            i_instruction,
  input wire tmc_pkg::tmc_port_out_t o_port,
  input wire logic [7:0]             i_in_data,
  input wire logic                   i_interrupt
);
  logic       exec_q;
  logic [3:0] op;

  // Phase from reset; valid only because every word takes two cycles
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) exec_q <= 1'b0;
    else exec_q <= ~exec_q;
  end
  assign op = i_instruction[15:12];

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);

  sequence s_exec(logic [3:0] code);
    exec_q && !i_interrupt && op == code;
  endsequence

  a_addr_hold: assert property (
    $changed(o_address) |=> $stable(o_address))
    else $error("address held for only one cycle");
  a_reset_start: assert property (
    $rose(i_arst_n) |-> o_address == 8'h00 && o_port == '0 ##1 o_address == 8'h00)
    else $error("core did not start at address zero");
  a_pc_step: assert property (
    exec_q && !i_interrupt && op < 4'hd |=> o_address == 8'($past(o_address) + 8'h01))
    else $error("address did not step by one");
  a_jump_abs: assert property (
    s_exec(tmc_pkg::OP_JUMP) ##0 !i_instruction[10] |=> o_address == $past(i_instruction[7:0]))
    else $error("jump went to wrong address");
  a_call_abs: assert property (
    s_exec(tmc_pkg::OP_CALL) ##0 !i_instruction[10] |=> o_address == $past(i_instruction[7:0]))
    else $error("call went to wrong address");
  a_out_strobe: assert property (
    s_exec(tmc_pkg::OP_OUT_K) |=> o_port.wr_strobe && o_port.port_select == $past(i_instruction[7:0]))
    else $error("output without strobe or port");
  a_in_strobe: assert property (
    s_exec(tmc_pkg::OP_IN_K) |=> o_port.rd_strobe && o_port.port_select == $past(i_instruction[7:0]))
    else $error("input without strobe or port");
  a_strobe_gap: assert property (
    o_port.wr_strobe || o_port.rd_strobe |=> !o_port.wr_strobe && !o_port.rd_strobe)
    else $error("strobe longer than one cycle");
  a_one_strobe: assert property (
    o_port.wr_strobe |-> !o_port.rd_strobe)
    else $error("both strobes high");
  a_sel_hold: assert property (
    !o_port.wr_strobe && !o_port.rd_strobe |-> $stable(o_port.port_select) && $stable(o_port.out_data))
    else $error("port fields moved without strobe");
endmodule // tmc_core_assertions

bind tmc_core tmc_core_assertions u_chk (
  .i_clock       (i_clock),
  .i_arst_n      (i_arst_n),
  .o_address     (o_address),
  .i_instruction (i_instruction),
  .o_port        (o_port),
  .i_in_data     (i_in_data),
  .i_interrupt   (i_interrupt)
);
`default_nettype wire

// ### bench/tmc_partner.sv
/*
  Program ROM and user port logic facing tmc_core.
  Assumes the bench fills mem before releasing reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tmc_partner (
  // Clock
  input  wire logic                   i_clock,
  // Program ROM
  input  wire logic [7:0]             i_address,
  output logic      [15:0]            o_instruction,
  // User ports
  input  wire tmc_pkg::tmc_port_out_t i_port,
  output logic      [7:0]             o_in_data,
  output logic      [7:0]             o_last_data
);
  logic [15:0] mem [256];

  always_ff @(posedge i_clock) begin
    o_instruction <= mem[i_address];
  end
  // Unselected input shows a moving pattern, never the last byte
  assign o_in_data = i_port.rd_strobe ? (i_port.port_select ^ 8'h3c) : ~o_instruction[7:0];
  always_ff @(posedge i_clock) begin
    if (i_port.wr_strobe) o_last_data <= i_port.out_data;
  end
endmodule // tmc_partner
`default_nettype wire

// ### bench/testbench.sv
/*
  Self-checking bench for tmc_core with the ROM and port model.
  Programs are written into the model's memory before each reset.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                   i_clock;
  logic                   i_arst_n;
  logic                   i_interrupt;
  logic [7:0]             o_address;
  logic [7:0]             i_in_data;
  logic [7:0]             last_data;
  logic [15:0]            i_instruction;
  tmc_pkg::tmc_port_out_t o_port;
  int                     n_fail = 0;
  int                     cmp_count = 0;

  tmc_core dut (
    .i_clock(i_clock), .i_arst_n(i_arst_n), .o_address(o_address), .i_instruction(i_instruction),
    .o_port(o_port), .i_in_data(i_in_data), .i_interrupt(i_interrupt));
  tmc_partner u_far (
    .i_clock(i_clock), .i_address(o_address), .o_instruction(i_instruction),
    .i_port(o_port), .o_in_data(i_in_data), .o_last_data(last_data));

  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic prog(input logic [7:0] base, input logic [15:0] w[]);
    foreach (w[i]) u_far.mem[8'(base + i)] = w[i];
  endtask

  task automatic rst();
    @(negedge i_clock);
    i_arst_n = 1'b0;
    repeat (4) @(negedge i_clock);
    chk("reset address", 8'h00, o_address);
    i_arst_n = 1'b1;
  endtask

  // Bounded wait for an address or a write strobe
  task automatic await(input bit on_addr, input logic [7:0] a, output int n);
    bit hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n < 500) begin
      @(negedge i_clock);
      n++;
      hit = on_addr ? (o_address === a) : (o_port.wr_strobe === 1'b1);
    end
    if (!hit) begin
      n_fail++;
      $display("MISMATCH wait expected event seen timeout");
      results();
    end
  endtask

  task automatic exp_wr(input logic [7:0] port, input logic [7:0] data);
    int n;
    await(1'b0, 8'h00, n);
    chk("port_select", port, o_port.port_select);
    chk("out_data", data, o_port.out_data);
    @(negedge i_clock);
    chk("captured data", data, last_data);
  endtask

  task automatic t_alu();
    prog(8'h00, '{16'h00f0, 16'h4020, 16'h0101, 16'h5100, 16'hb010, 16'hb111, 16'h6103, 16'h7000,
                  16'h8013, 16'hb012, 16'h30f0, 16'hd40d, 16'hb0ee, 16'hb113, 16'hd00e});
    rst();
    exp_wr(8'h10, 8'h10);
    exp_wr(8'h11, 8'h02);
    exp_wr(8'h12, 8'hf0);
    exp_wr(8'h13, 8'hff);
  endtask

  task automatic t_io();
    prog(8'h00, '{16'h0240, 16'ha377, 16'hc321, 16'hcf20, 16'hbf41, 16'hd005});
    rst();
    exp_wr(8'h40, 8'h4b);
    exp_wr(8'h41, 8'h7c);
  endtask

  // Recursion reaches exactly fifteen return addresses
  task automatic t_stack();
    prog(8'h00, '{16'h010f, 16'h0600, 16'he010, 16'hb650, 16'hd004});
    prog(8'h10, '{16'h6101, 16'he510, 16'h4601, 16'hf000});
    rst();
    exp_wr(8'h50, 8'h0f);
  endtask

  // Main loop stays on good path only while both flags are set
  task automatic t_int();
    int n;
    prog(8'h00, '{16'h08ff, 16'h4801, 16'hf020, 16'hd605, 16'hb961, 16'hd504, 16'hd003});
    prog(8'hf0, '{16'h0901, 16'h4901, 16'hb960, 16'hf011});
    prog(8'hff, '{16'hd0f0});
    i_interrupt = 1'b1;
    rst();
    await(1'b1, 8'hff, n);
    chk("cycles to vector", 8'd8, 8'(n));
    exp_wr(8'h60, 8'h02);
    i_interrupt = 1'b0;
    repeat (20) @(negedge i_clock);
    i_interrupt = 1'b1;
    exp_wr(8'h60, 8'h02);
    i_interrupt = 1'b0;
  endtask

  // Flags still set from the previous loop when reset hits
  task automatic t_reset();
    prog(8'h00, '{16'hd608, 16'hd408, 16'hb370, 16'hd003});
    prog(8'h08, '{16'hb371});
    rst();
    exp_wr(8'h70, 8'h4b);
  endtask

  task automatic t_wrap();
    int n;
    prog(8'h00, '{16'hd0fe});
    prog(8'hfe, '{16'h0b00, 16'h0b00});
    rst();
    await(1'b1, 8'hff, n);
    repeat (2) @(negedge i_clock);
    chk("wrapped address", 8'h00, o_address);
  endtask

  // Shift chain folds carry through; a disabled interrupt must stay ignored
  task automatic t_logic();
    prog(8'h00, '{16'h0a81, 16'h9a08, 16'h9a0b, 16'h9a04, 16'h9a03, 16'h9a0c, 16'hba80,
                  16'h2a10, 16'h1a0f, 16'hf020, 16'hf030, 16'hba81, 16'hd00b});
    prog(8'hff, '{16'hba90});
    rst();
    exp_wr(8'h80, 8'h83);
    exp_wr(8'h81, 8'h03);
    i_interrupt = 1'b1;
    exp_wr(8'h81, 8'h03);
    i_interrupt = 1'b0;
  endtask

  initial begin
    i_arst_n = 1'b0;
    i_interrupt = 1'b0;
    t_alu();
    t_io();
    t_stack();
    t_int();
    t_reset();
    t_wrap();
    t_logic();
    results();
  end
endmodule // testbench
`default_nettype wire
